/* hdl/rep_health_pkg.sv */
// Package for the repetition health test: widths, cutoff and carriers.
// Assumes a single 200 MHz clock domain; no software-visible registers.
package rep_health_pkg;

    // ------------------------------------------------------------------
    // Sample and cutoff sizing
    // ------------------------------------------------------------------
    localparam int RAW_W = 8;
    localparam int CONCAT_N = 8;
    localparam int SAMPLE_W = RAW_W * CONCAT_N;
    localparam int CUTOFF_W = 16;
    localparam logic [CUTOFF_W-1:0] CUTOFF_DEF = 16'h0006;
    localparam logic [CUTOFF_W-1:0] CUTOFF_MIN = 16'h0002;
    localparam logic [CUTOFF_W-1:0] COUNT_ONE = 16'h0001;
    localparam int ALPHA_LOG2_NEG = 30;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [RAW_W-1:0] data;
    } raw_word_s;

    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] data;
    } sample_s;

    typedef enum logic [1:0] {
        ST_EMPTY,
        ST_RUN,
        ST_FAIL
    } test_state_e;

endpackage : rep_health_pkg

/* hdl/repetition_health_test.sv */
// Repetition health test on a noise source sample stream.
// Assumes raw words come from logic on i_clk_sys; cutoff is held static.
`timescale 1ns/1ps

module repetition_health_test
    import rep_health_pkg::*;
#(
    parameter int RAW_WIDTH = RAW_W,
    parameter int CONCAT_WORDS = CONCAT_N,
    parameter int CNT_WIDTH = CUTOFF_W
) (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Configuration
    input wire logic [CNT_WIDTH-1:0] i_cutoff,
    // Noise source raw words
    input wire raw_word_s i_raw,
    // Consumer side
    output sample_s o_sample,
    output logic o_fail
);

    // ------------------------------------------------------------------
    // Assembly of the effective sample
    // ------------------------------------------------------------------
    localparam int IDX_W = $clog2(CONCAT_WORDS + 1);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CONCAT_WORDS - 1);
    localparam int KEEP_W = SAMPLE_W - RAW_WIDTH;

    logic [SAMPLE_W-1:0] shift_acc;
    logic [IDX_W-1:0] word_idx;
    logic asm_valid;
    logic [SAMPLE_W-1:0] asm_data;

    // Wider samples make a cutoff of two usable without false alarms
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            shift_acc <= '0;
            word_idx <= '0;
            asm_valid <= 1'b0;
            asm_data <= '0;
        end else if (i_clk_en) begin
            asm_valid <= 1'b0;
            if (i_raw.valid) begin
                shift_acc <= {shift_acc[KEEP_W-1:0], i_raw.data};
                if (word_idx == LAST_IDX) begin
                    word_idx <= '0;
                    asm_valid <= 1'b1;
                    asm_data <= {shift_acc[KEEP_W-1:0], i_raw.data};
                end else begin
                    word_idx <= word_idx + IDX_W'(1);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Repetition count
    // ------------------------------------------------------------------
    test_state_e state;
    logic [SAMPLE_W-1:0] reference;
    logic [CNT_WIDTH-1:0] rep_count;
    logic [CNT_WIDTH-1:0] cutoff_eff;
    logic [CNT_WIDTH-1:0] next_count;
    logic same;
    localparam logic [CNT_WIDTH-1:0] CNT_ONE = CNT_WIDTH'(COUNT_ONE);
    localparam logic [CNT_WIDTH-1:0] CNT_MIN = CNT_WIDTH'(CUTOFF_MIN);

    // One decode for the trip point keeps state and flag in step
    function automatic logic at_cutoff(
        input logic [CNT_WIDTH-1:0] cnt,
        input logic [CNT_WIDTH-1:0] lim
    );
        return cnt == lim;
    endfunction : at_cutoff

    // A cutoff of one would fail on the first changed sample and zero would never trip; clamp it
    // Cutoff is computed offline as ceil(1 + 30 / H)
    assign cutoff_eff = (i_cutoff < CNT_MIN) ? CNT_MIN : i_cutoff;
    assign same = (asm_data == reference);
    assign next_count = (state == ST_RUN && same) ?
        rep_count + CNT_ONE : CNT_ONE;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= ST_EMPTY;
            reference <= '0;
            rep_count <= '0;
        end else if (i_clk_en && asm_valid) begin
            case (state)
                ST_EMPTY: begin
                    reference <= asm_data;
                    rep_count <= CNT_ONE;
                    state <= ST_RUN;
                end
                ST_RUN: begin
                    rep_count <= next_count;
                    if (!same) begin
                        reference <= asm_data;
                    end
                    if (at_cutoff(next_count, cutoff_eff)) begin
                        state <= ST_FAIL;
                    end
                end
                ST_FAIL: begin
                    state <= ST_FAIL;
                end
                default: begin
                    state <= ST_EMPTY;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    logic hit;
    assign hit = asm_valid && state == ST_RUN
        && at_cutoff(next_count, cutoff_eff);

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_fail <= 1'b0;
        end else if (i_clk_en && hit) begin
            o_fail <= 1'b1;
        end
    end

    // Failing sample itself is withheld, at a cost of one cycle latency
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_sample <= '0;
        end else if (i_clk_en) begin
            o_sample.valid <= asm_valid && !hit && !o_fail
                && state != ST_FAIL;
            if (asm_valid) begin
                o_sample.data <= asm_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_fail_sticky: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_fail |=> o_fail)
        else $error("fail flag dropped without reset");

    a_no_fwd_fail: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_fail |=> !o_sample.valid)
        else $error("sample forwarded while failed");

    a_hit_raises: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_clk_en && asm_valid && state == ST_RUN && same
            && rep_count + COUNT_ONE == cutoff_eff) |=> o_fail)
        else $error("cutoff reached without failure");

    a_first_load: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_clk_en && asm_valid && state == ST_EMPTY)
        |=> rep_count == COUNT_ONE && reference == $past(asm_data))
        else $error("first sample not loaded");

    a_diff_reload: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_clk_en && asm_valid && state == ST_RUN && !same)
        |=> rep_count == COUNT_ONE && reference == $past(asm_data))
        else $error("new value did not restart count");

    a_same_incr: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_clk_en && asm_valid && state == ST_RUN && same)
        |=> rep_count == $past(rep_count) + COUNT_ONE)
        else $error("repeat did not increment count");

    a_pair_fails: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_clk_en && asm_valid && state == ST_RUN && same
            && cutoff_eff == CUTOFF_MIN) |=> o_fail)
        else $error("repeated pair not flagged at cutoff two");

    a_count_bound: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        state == ST_RUN |-> rep_count < cutoff_eff)
        else $error("count passed cutoff");

    a_word_pack: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_clk_en && i_raw.valid && word_idx == LAST_IDX)
        |=> asm_valid && asm_data[RAW_W-1:0] == $past(i_raw.data))
        else $error("wide sample not assembled");

    a_freeze_hold: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        !i_clk_en |=> $stable(rep_count) && $stable(reference)
            && $stable(word_idx) && $stable(o_sample) && $stable(o_fail))
        else $error("state moved while clock enable low");

    c_fail_seen: cover property (
        @(posedge i_clk_sys) disable iff (i_sys_rst) $rose(o_fail));
    c_reload: cover property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        asm_valid && state == ST_RUN && !same);
    c_forward: cover property (
        @(posedge i_clk_sys) disable iff (i_sys_rst) o_sample.valid);
    c_freeze: cover property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        !i_clk_en && i_raw.valid);
    c_pair_fail: cover property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(o_fail) && cutoff_eff == CNT_MIN);

endmodule : repetition_health_test

/* testbench/noise_src_model.sv */
// Noise source model: splits one wide sample into raw words.
// Assumes the bench pulses i_start only while o_busy is low.
`timescale 1ns/1ps
module noise_src_model
    import rep_health_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Bench request
    input wire logic i_start,
    input wire logic [SAMPLE_W-1:0] i_value,
    // Raw words to the test
    output raw_word_s o_raw,
    output logic o_busy
);
    int idx;
    logic [SAMPLE_W-1:0] sh;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            idx <= 0;
            sh <= '0;
            o_raw <= '0;
            o_busy <= 1'b0;
        end else if (i_start && !o_busy) begin
            sh <= i_value;
            idx <= CONCAT_N;
            o_busy <= 1'b1;
        end else if (idx > 0) begin
            // Top byte first, one word per cycle
            o_raw.valid <= 1'b1;
            o_raw.data <= sh[SAMPLE_W-1 -: RAW_W];
            sh <= sh << RAW_W;
            idx <= idx - 1;
        end else begin
            // Idle data toggles so a stale word never looks valid
            o_raw.valid <= 1'b0;
            o_raw.data <= ~o_raw.data;
            o_busy <= 1'b0;
        end
    end
endmodule : noise_src_model

/* testbench/repetition_health_test_bench.sv */
// Bench for the repetition health test with a noise source model.
// Assumes clock enable drops only in the freeze scenario; cutoff changes
// only in reset.
`timescale 1ns/1ps
module repetition_health_test_bench
    import rep_health_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [CUTOFF_W-1:0] cutoff = 16'h0003;
    logic start = 1'b0;
    logic clk_en = 1'b1;
    logic [SAMPLE_W-1:0] value = '0;
    raw_word_s raw;
    sample_s o_sample;
    logic o_fail;
    logic busy;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    localparam logic [SAMPLE_W-1:0] VA = 64'h0123456789ABCDEF;
    localparam logic [SAMPLE_W-1:0] VB = 64'hF0E1D2C3B4A59687;
    initial forever #2.5 i_clk_sys = ~i_clk_sys;
    noise_src_model i_src (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_start(start), .i_value(value), .o_raw(raw), .o_busy(busy));
    repetition_health_test i_dut (.i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst), .i_clk_en(clk_en), .i_cutoff(cutoff),
        .i_raw(raw), .o_sample(o_sample), .o_fail(o_fail));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic do_reset(logic [CUTOFF_W-1:0] c);
        @(posedge i_clk_sys);
        i_sys_rst <= 1'b1;
        cutoff <= c;
        repeat (10) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
    endtask : do_reset
    // One sample; the window covers the fixed ten-cycle answer
    task automatic send(logic [SAMPLE_W-1:0] v, logic ev, logic ef);
        int pulses;
        logic [SAMPLE_W-1:0] seen;
        pulses = 0;
        seen = '0;
        @(posedge i_clk_sys);
        value <= v;
        start <= 1'b1;
        @(posedge i_clk_sys);
        start <= 1'b0;
        repeat (14) begin
            @(posedge i_clk_sys);
            #1;
            if (o_sample.valid === 1'b1) begin
                pulses++;
                seen = o_sample.data;
            end
        end
        check("pulses", 64'(pulses), {63'h0, ev});
        if (ev) check("data", seen, v);
        check("fail", {63'h0, o_fail}, {63'h0, ef});
    endtask : send
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_count_to_cutoff();
        do_reset(16'h0003);
        send(VA, 1'b1, 1'b0);
        send(VA, 1'b1, 1'b0);
        send(VA, 1'b0, 1'b1);
        send(VB, 1'b0, 1'b1);
    endtask : t_count_to_cutoff
    task automatic t_reload();
        do_reset(16'h0003);
        send(VA, 1'b1, 1'b0);
        send(VA, 1'b1, 1'b0);
        send(VB, 1'b1, 1'b0);
        send(VB, 1'b1, 1'b0);
        send(VB, 1'b0, 1'b1);
    endtask : t_reload
    task automatic t_pair();
        // Cutoff below two behaves as two
        do_reset(16'h0001);
        send(VA, 1'b1, 1'b0);
        send(VB, 1'b1, 1'b0);
        send(VB, 1'b0, 1'b1);
        do_reset(16'h0002);
        send(VB, 1'b1, 1'b0);
        send(VB, 1'b0, 1'b1);
    endtask : t_pair
    task automatic t_freeze();
        // Words offered while frozen are lost, so the count waits
        do_reset(16'h0003);
        send(VA, 1'b1, 1'b0);
        @(posedge i_clk_sys);
        clk_en <= 1'b0;
        send(VA, 1'b0, 1'b0);
        @(posedge i_clk_sys);
        clk_en <= 1'b1;
        send(VA, 1'b1, 1'b0);
        send(VA, 1'b0, 1'b1);
    endtask : t_freeze
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        t_count_to_cutoff();
        t_reload();
        t_pair();
        t_freeze();
        test_done();
    end
endmodule : repetition_health_test_bench
